// file: aomc_pkg.sv
// Constants and types for the accelerometer operating-mode controller
package aomc_pkg;
    localparam int AOMC_DATA_W   = 12;
    localparam int AOMC_BYTE_W   = 8;
    localparam int AOMC_LSB_PAD  = 4;
    localparam int AOMC_RAW_W    = 14;
    localparam int AOMC_GEXP_2G  = 10;
    localparam int AOMC_GEXP_4G  = 9;
    localparam int AOMC_GEXP_8G  = 8;
    localparam int AOMC_BOOT_NS  = 500000;
    localparam int AOMC_CLK_NS   = 100;
    localparam int AOMC_BOOT_CYC = (AOMC_BOOT_NS + AOMC_CLK_NS - 1)
                                   / AOMC_CLK_NS;
    localparam logic [11:0] AOMC_POS_MAX = 12'h7ff;
    localparam logic [11:0] AOMC_NEG_MIN = 12'h800;
    localparam logic [11:0] AOMC_ZERO    = 12'h000;
    localparam logic [1:0]  AOMC_FS_2G   = 2'h0;
    localparam logic [1:0]  AOMC_FS_4G   = 2'h1;
    localparam logic [1:0]  AOMC_FS_8G   = 2'h2;
    localparam logic [7:0]  AOMC_OUT_BASE = 8'h00;

    typedef enum logic [2:0] {
        AOMC_OFF,
        AOMC_BOOT,
        AOMC_STANDBY,
        AOMC_WAKE,
        AOMC_SLEEP
    } aomc_state_t;
endpackage : aomc_pkg

// file: aomc_mode_ctrl.sv
// Operating-mode sequencer and axis output formatter of the accelerometer
//
// Contract
// - As bus slave never hold serial clock low; clock-hold output stays off.
// - Counts per g: 1024 at 2 g, 512 at 4 g, 256 at 8 g.
// - Axis results are two's complement, zero g at mid-range, from address 0; here zero g reads as code 000, not mid-range.
// - Run-enable clear: only digital on, analog and clocks off, bus alive.
// - Run-enable set: enter ACTIVE, enable all blocks, bus stays alive.
// - On STANDBY to ACTIVE, a register subset returns to reset values.
// - SLEEP and WAKE live inside ACTIVE; never entered with run-enable clear.
// - Self-test output is real plus electrostatic stimulus, scaled by range.
// - Powered off: everything shut down, no serial bus participation.
// - Each axis is 12 bits; upper byte register holds eight MSBs.
`timescale 1ns/1ps

module aomc_mode_ctrl
    import aomc_pkg::*;
#(
    parameter int BOOT_CYC = AOMC_BOOT_CYC
)
(
    input  wire logic                  clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  power_good_i,
    input  wire logic                  run_enable_i,
    input  wire logic                  sleep_req_i,
    input  wire logic                  self_test_i,
    input  wire logic [1:0]            full_scale_i,
    input  wire logic                  sample_valid_i,
    input  wire logic [3*AOMC_RAW_W-1:0] accel_mg_i,
    input  wire logic [3*AOMC_RAW_W-1:0] stim_mg_i,
    output logic                       bus_enable_o,
    output logic                       scl_hold_oe_o,
    output logic                       analog_enable_o,
    output logic                       int_clk_enable_o,
    output logic                       active_o,
    output logic                       sleep_o,
    output logic                       soft_reset_o,
    output logic [7:0]                 out_base_o,
    output logic [3*AOMC_BYTE_W-1:0]   out_msb_o,
    output logic [3*AOMC_BYTE_W-1:0]   out_lsb_o,
    output logic                       data_ready_o
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: power, mode and select levels come from pins
    logic [1:0] pg_s, run_s, slp_s, st_s;
    logic [1:0] fs_s0, fs_s1;

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            pg_s  <= 2'h0;
            run_s <= 2'h0;
            slp_s <= 2'h0;
            st_s  <= 2'h0;
            fs_s0 <= 2'h0;
            fs_s1 <= 2'h0;
        end
        else
        begin
            pg_s  <= {pg_s[0], power_good_i};
            run_s <= {run_s[0], run_enable_i};
            slp_s <= {slp_s[0], sleep_req_i};
            st_s  <= {st_s[0], self_test_i};
            fs_s0 <= full_scale_i;
            fs_s1 <= fs_s0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode state machine
    aomc_state_t state, next_state;
    logic [$clog2(BOOT_CYC+1)-1:0] boot_cnt, next_boot_cnt;
    logic next_soft_reset;

    always_comb
    begin
        next_state      = state;
        next_boot_cnt   = boot_cnt;
        next_soft_reset = 1'b0;
        if (!pg_s[1])
        begin
            next_state    = AOMC_OFF;
            next_boot_cnt = '0;
        end
        else
        begin
            unique case (state)
                AOMC_OFF:
                    next_state = AOMC_BOOT;
                AOMC_BOOT:
                begin
                    // Bus held off until trim load completes
                    if (boot_cnt == ($clog2(BOOT_CYC+1))'(BOOT_CYC - 1))
                        next_state = AOMC_STANDBY;
                    else
                        next_boot_cnt = boot_cnt + 1'b1;
                end
                AOMC_STANDBY:
                begin
                    if (run_s[1])
                    begin
                        next_state      = AOMC_WAKE;
                        next_soft_reset = 1'b1;
                    end
                end
                AOMC_WAKE:
                begin
                    if (!run_s[1])
                        next_state = AOMC_STANDBY;
                    else if (slp_s[1])
                        next_state = AOMC_SLEEP;
                end
                AOMC_SLEEP:
                begin
                    if (!run_s[1])
                        next_state = AOMC_STANDBY;
                    else if (!slp_s[1])
                        next_state = AOMC_WAKE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state        <= AOMC_OFF;
            boot_cnt     <= '0;
            soft_reset_o <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            boot_cnt     <= next_boot_cnt;
            soft_reset_o <= next_soft_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-domain enables, registered from the next state
    logic next_bus, next_ana, next_act, next_slp;

    always_comb
    begin
        next_bus = (next_state == AOMC_STANDBY) ||
                   (next_state == AOMC_WAKE) ||
                   (next_state == AOMC_SLEEP);
        next_act = (next_state == AOMC_WAKE) ||
                   (next_state == AOMC_SLEEP);
        next_ana = next_act;
        next_slp = (next_state == AOMC_SLEEP);
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            bus_enable_o     <= 1'b0;
            analog_enable_o  <= 1'b0;
            int_clk_enable_o <= 1'b0;
            active_o         <= 1'b0;
            sleep_o          <= 1'b0;
            scl_hold_oe_o    <= 1'b0;
            out_base_o       <= AOMC_OUT_BASE;
        end
        else
        begin
            bus_enable_o     <= next_bus;
            analog_enable_o  <= next_ana;
            int_clk_enable_o <= next_ana;
            active_o         <= next_act;
            sleep_o          <= next_slp;
            // Never stretches the clock, so the hold driver stays off
            scl_hold_oe_o    <= 1'b0;
            out_base_o       <= AOMC_OUT_BASE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Axis formatting: mg in, scaled counts out, saturated to 12 bits
    logic [3*AOMC_BYTE_W-1:0] next_msb, next_lsb;
    logic next_rdy;

    function automatic logic [11:0] aomc_scale(
        input logic signed [AOMC_RAW_W-1:0] a,
        input logic signed [AOMC_RAW_W-1:0] s,
        input logic                         st,
        input logic [1:0]                   fs
    );
        logic signed [31:0] sum;
        logic signed [31:0] cnt;
        sum = 32'(a) + (st ? 32'(s) : 32'sh0);
        // Counts = mg * 2^exp / 1000; truncation keeps the encoder cheap
        unique case (fs)
            AOMC_FS_4G: cnt = (sum <<< AOMC_GEXP_4G) / 1000;
            AOMC_FS_8G: cnt = (sum <<< AOMC_GEXP_8G) / 1000;
            default:    cnt = (sum <<< AOMC_GEXP_2G) / 1000;
        endcase
        // Signed bounds, so negative counts are not read as huge ones
        if (cnt > $signed(32'(AOMC_POS_MAX)))
            aomc_scale = AOMC_POS_MAX;
        else if (cnt < -$signed(32'(AOMC_NEG_MIN)))
            aomc_scale = AOMC_NEG_MIN;
        else
            aomc_scale = cnt[11:0];
    endfunction : aomc_scale

    logic [11:0] ax [3];

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_axis
            assign ax[g] = aomc_scale(
                accel_mg_i[g*AOMC_RAW_W +: AOMC_RAW_W],
                stim_mg_i[g*AOMC_RAW_W +: AOMC_RAW_W],
                st_s[1], fs_s1);
        end
    endgenerate

    always_comb
    begin
        next_msb = out_msb_o;
        next_lsb = out_lsb_o;
        next_rdy = 1'b0;
        if (soft_reset_o || state == AOMC_OFF)
        begin
            next_msb = '0;
            next_lsb = '0;
        end
        else if (sample_valid_i && active_o)
        begin
            for (int i = 0; i < 3; i++)
            begin
                next_msb[i*AOMC_BYTE_W +: AOMC_BYTE_W] =
                    ax[i][AOMC_DATA_W-1 -: AOMC_BYTE_W];
                next_lsb[i*AOMC_BYTE_W +: AOMC_BYTE_W] =
                    {ax[i][AOMC_LSB_PAD-1:0], 4'h0};
            end
            next_rdy = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            out_msb_o    <= '0;
            out_lsb_o    <= '0;
            data_ready_o <= 1'b0;
        end
        else
        begin
            out_msb_o    <= next_msb;
            out_lsb_o    <= next_lsb;
            data_ready_o <= next_rdy;
        end
    end

endmodule : aomc_mode_ctrl

// file: aomc_mode_ctrl_props.sv
// Checker for mode sequencing and output format of the mode controller
`timescale 1ns/1ps
module aomc_mode_ctrl_chk
    import aomc_pkg::*;
(
    input  wire logic                     clk_i,
    input  wire logic                     resetn_i,
    input  wire logic                     power_good_i,
    input  wire logic                     run_enable_i,
    input  wire logic                     sample_valid_i,
    input  wire logic                     bus_enable_o,
    input  wire logic                     scl_hold_oe_o,
    input  wire logic                     analog_enable_o,
    input  wire logic                     int_clk_enable_o,
    input  wire logic                     active_o,
    input  wire logic                     sleep_o,
    input  wire logic                     soft_reset_o,
    input  wire logic [7:0]               out_base_o,
    input  wire logic [3*AOMC_BYTE_W-1:0] out_lsb_o,
    input  wire logic                     data_ready_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Three samples cover the two-stage sync plus the enable output register
    sequence s_pwr_gone; !power_good_i [*3]; endsequence
    sequence s_run_clear; !run_enable_i [*3]; endsequence
    sequence s_one_pulse; soft_reset_o ##1 !soft_reset_o; endsequence
    ////////////////////////////////////////////////////////////////////////
    a_no_clk_hold: assert property (!scl_hold_oe_o)
        else $error("clock hold driven");
    a_off_bus_dead: assert property (
        s_pwr_gone |=> !bus_enable_o && !analog_enable_o && !active_o)
        else $error("bus or blocks alive without power");
    a_standby_quiet: assert property (
        s_run_clear |=> !analog_enable_o && !int_clk_enable_o && !active_o)
        else $error("blocks on with run-enable clear");
    a_active_all_on: assert property (
        active_o |-> analog_enable_o && int_clk_enable_o && bus_enable_o)
        else $error("block off while active");
    a_sleep_in_active: assert property (sleep_o |-> active_o)
        else $error("sleep outside active");
    a_soft_rst_entry: assert property ($rose(active_o) |-> s_one_pulse)
        else $error("no single clear pulse on activation");
    a_ready_cause: assert property (
        data_ready_o == ($past(sample_valid_i) && $past(active_o)
                         && !$past(soft_reset_o)))
        else $error("data ready without accepted sample");
    a_base_fixed: assert property (out_base_o == AOMC_OUT_BASE)
        else $error("output base moved");
    a_lsb_pad_zero: assert property (
        out_lsb_o[3:0] == 4'h0 && out_lsb_o[11:8] == 4'h0
        && out_lsb_o[19:16] == 4'h0)
        else $error("low byte padding not zero");
endmodule : aomc_mode_ctrl_chk

bind aomc_mode_ctrl aomc_mode_ctrl_chk u_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .power_good_i(power_good_i),
    .run_enable_i(run_enable_i), .sample_valid_i(sample_valid_i),
    .bus_enable_o(bus_enable_o), .scl_hold_oe_o(scl_hold_oe_o),
    .analog_enable_o(analog_enable_o), .int_clk_enable_o(int_clk_enable_o),
    .active_o(active_o), .sleep_o(sleep_o), .soft_reset_o(soft_reset_o),
    .out_base_o(out_base_o), .out_lsb_o(out_lsb_o),
    .data_ready_o(data_ready_o));

// file: aomc_front_model.sv
// Sensor front-end model that hands samples to the controller
`timescale 1ns/1ps
module aomc_front_model
    import aomc_pkg::*;
(
    input  wire logic                   clk_i,
    output logic                        sample_valid_o,
    output logic [3*AOMC_RAW_W-1:0]     accel_o,
    output logic [3*AOMC_RAW_W-1:0]     stim_o
);
    initial
    begin
        sample_valid_o = 1'b0;
        accel_o = '0;
        stim_o = '0;
    end

    task automatic send(logic [3*AOMC_RAW_W-1:0] a,
                        logic [3*AOMC_RAW_W-1:0] s);
        @(negedge clk_i);
        sample_valid_o = 1'b1;
        accel_o = a;
        stim_o = s;
        @(negedge clk_i);
        sample_valid_o = 1'b0;
        // Data not held past the pulse, so stale use shows up
        accel_o = ~a;
        stim_o = ~s;
    endtask : send
endmodule : aomc_front_model

// file: tb_accel_operating_mode_control.sv
// Self-checking bench for the operating-mode controller
`timescale 1ns/1ps
module tb_accel_operating_mode_control;
    import aomc_pkg::*;
    logic clk_i, resetn_i, power_good_i, run_enable_i, sleep_req_i;
    logic self_test_i, sample_valid_i, sr;
    logic [1:0] full_scale_i;
    logic [3*AOMC_RAW_W-1:0] accel_mg_i, stim_mg_i;
    logic bus_enable_o, scl_hold_oe_o, analog_enable_o, int_clk_enable_o;
    logic active_o, sleep_o, soft_reset_o, data_ready_o;
    logic [7:0] out_base_o;
    logic [3*AOMC_BYTE_W-1:0] out_msb_o, out_lsb_o;
    wire logic [5:0] mode = {bus_enable_o, scl_hold_oe_o, analog_enable_o,
                             int_clk_enable_o, active_o, sleep_o};
    int errors = 0;
    int n_checks = 0;

    aomc_mode_ctrl #(.BOOT_CYC(4)) DUT (.clk_i(clk_i), .resetn_i(resetn_i),
        .power_good_i(power_good_i), .run_enable_i(run_enable_i),
        .sleep_req_i(sleep_req_i), .self_test_i(self_test_i),
        .full_scale_i(full_scale_i), .sample_valid_i(sample_valid_i),
        .accel_mg_i(accel_mg_i), .stim_mg_i(stim_mg_i),
        .bus_enable_o(bus_enable_o), .scl_hold_oe_o(scl_hold_oe_o),
        .analog_enable_o(analog_enable_o), .int_clk_enable_o(int_clk_enable_o),
        .active_o(active_o), .sleep_o(sleep_o), .soft_reset_o(soft_reset_o),
        .out_base_o(out_base_o), .out_msb_o(out_msb_o), .out_lsb_o(out_lsb_o),
        .data_ready_o(data_ready_o));
    aomc_front_model fm (.clk_i(clk_i), .sample_valid_o(sample_valid_i),
        .accel_o(accel_mg_i), .stim_o(stim_mg_i));

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    function automatic logic [11:0] cnt(int mg, int e);
        int v;
        v = mg * (1 << e) / 1000;
        v = (v > 2047) ? 2047 : ((v < -2048) ? -2048 : v);
        return v[11:0];
    endfunction : cnt

    // Pins pass a two-stage sync, so four cycles cover the change
    task automatic pins(logic pg, logic re, logic sq, logic st,
                        logic [1:0] fs);
        power_good_i = pg;
        run_enable_i = re;
        sleep_req_i = sq;
        self_test_i = st;
        full_scale_i = fs;
        sr = 1'b0;
        repeat (4)
        begin
            @(negedge clk_i);
            sr = sr | soft_reset_o;
        end
    endtask : pins

    task automatic samp(int e, logic st, int m[6]);
        logic [11:0] v;
        fm.send({14'(m[2]), 14'(m[1]), 14'(m[0])},
                {14'(m[5]), 14'(m[4]), 14'(m[3])});
        chk("ready", data_ready_o, 24'h1);
        for (int i = 0; i < 3; i++)
        begin
            v = cnt(m[i] + (st ? m[i+3] : 0), e);
            chk("msb", out_msb_o[8*i +: 8], v[11:4]);
            chk("lsb", out_lsb_o[8*i +: 8], {v[3:0], 4'h0});
        end
    endtask : samp

    task automatic t_activate;
        pins(1, 1, 0, 0, AOMC_FS_2G);
        chk("soft_reset", sr, 24'h1);
        chk("active", mode, 24'h2e);
        chk("cleared", out_msb_o, 24'h0);
        chk("cleared_lsb", out_lsb_o, 24'h0);
        $display("test activate done");
    endtask : t_activate

    task automatic t_scale;
        for (int r = 0; r < 3; r++)
        begin
            pins(1, 1, 0, 0, 2'(r));
            samp(AOMC_GEXP_2G - r, 0, '{1000, -1000, 0, 300, 0, 0});
        end
        pins(1, 1, 0, 1, AOMC_FS_4G);
        samp(AOMC_GEXP_4G, 1, '{4000, -300, 0, 250, 250, -100});
        $display("test scale done");
    endtask : t_scale

    task automatic t_sleep;
        pins(1, 1, 1, 0, AOMC_FS_2G);
        chk("sleep", mode, 24'h2f);
        pins(1, 1, 0, 0, AOMC_FS_2G);
        chk("wake", mode, 24'h2e);
        pins(1, 1, 1, 0, AOMC_FS_2G);
        chk("sleep_again", mode, 24'h2f);
        pins(1, 0, 1, 0, AOMC_FS_2G);
        chk("standby", mode, 24'h20);
        fm.send(42'h3e8, 42'h0);
        chk("refused", data_ready_o, 24'h0);
        t_activate();
        pins(0, 1, 0, 0, AOMC_FS_2G);
        chk("off", mode, 24'h0);
        $display("test sleep and off done");
    endtask : t_sleep

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (2000) @(posedge clk_i);
        errors++;
        final_report();
    end

    initial
    begin
        resetn_i = 1'b0;
        pins(1, 0, 0, 0, AOMC_FS_2G);
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        for (int i = 0; i < 40 && bus_enable_o !== 1'b1; i++)
            @(negedge clk_i);
        chk("boot", mode, 24'h20);
        chk("base", out_base_o, 24'(AOMC_OUT_BASE));
        $display("test boot done");
        t_activate();
        t_scale();
        t_sleep();
        final_report();
    end
endmodule : tb_accel_operating_mode_control
